/* logic/instant_oc_map.svh */
`ifndef INSTANT_OC_MAP_SVH
`define INSTANT_OC_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OC_CTRL_OFS      8'h00
`define OC_START_OFS     8'h04
`define OC_STATUS_OFS    8'h08
`define OC_EVSTAT_OFS    8'h0c
`define OC_EVEN_OFS      8'h10
`define OC_EVCLR_OFS     8'h14
`define OC_PEAK1_OFS     8'h18
`define OC_PEAK2_OFS     8'h1c
`define OC_PEAK3_OFS     8'h20

// ----------------------------------------
// Start current setting in percent
// ----------------------------------------
`define OC_START_MIN     12'h014
`define OC_START_MAX     12'hbb8
`define OC_START_DEF     12'h0c8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OC_MODE_MSB      1
`define OC_START_MSB     11
`define OC_EV_GEN_BIT    3
`define OC_ST_DIS_BIT    4
`define OC_ST_DBL_BIT    5

`endif

/* logic/instant_oc_pkg.sv */
package instant_oc_pkg;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_PEAK,
		MODE_FUND
	} opMode_t;

	typedef struct packed {
		opMode_t          mode;
		logic [11:0]      startPct;
		logic [2:0][15:0] peak;
		logic [15:0]      winCnt;
		logic [2:0]       trip;
		logic             anyTrip;
		logic [3:0]       evStat;
		logic [3:0]       evEn;
		logic             irq;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} ocState_t;

endpackage

/* logic/three_phase_instant_overcurrent.sv */
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "instant_oc_map.svh"
// How it works
// - Operation selector: off, peak based or fundamental based; off after reset.
// - Start current in percent, 20 to 3000 in steps of one, default 200.
// - A phase trips with no added delay when its measurement exceeds threshold.
// - Peak mode tracks a separate peak of each phase from its samples.
// - No trip output is asserted from the first clock edge that samples the disable input high while it stays high.
// - While the doubling input is high the threshold is twice the setting.
// - Three per-phase trip outputs, each from its own phase only.
// - General trip is the OR of the three phase trips.
module three_phase_instant_overcurrent #(
	parameter int PEAK_WINDOW = 20
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output      logic [31:0]               prdata,
	output      logic                      pready,
	output      logic                      pslverr,
	// Sampled phase currents
	input  wire logic                      sampleValid,
	input  wire logic signed [15:0]        phase1CurrentSample,
	input  wire logic signed [15:0]        phase2CurrentSample,
	input  wire logic signed [15:0]        phase3CurrentSample,
	// Fundamental RMS values
	input  wire logic [15:0]               phase1FundamentalRms,
	input  wire logic [15:0]               phase2FundamentalRms,
	input  wire logic [15:0]               phase3FundamentalRms,
	// Control inputs
	input  wire logic                      functionDisableIn,
	input  wire logic                      thresholdDoublingIn,
	// Trip outputs
	output      logic                      phase1TripOut,
	output      logic                      phase2TripOut,
	output      logic                      phase3TripOut,
	output      logic                      anyPhaseTripOut,
	// Interrupt
	output      logic                      irq
);
	import instant_oc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// The most negative sample maps to 16'h8000, which still fits unsigned.
	function automatic logic [15:0] absVal(input logic signed [15:0] s);
		logic [15:0] r;
		r = s[15] ? 16'(-s) : 16'(s);
		return r;
	endfunction

	function automatic logic [15:0] maxVal(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] r;
		r = (a > b) ? a : b;
		return r;
	endfunction

	function automatic logic [12:0] effThr(input logic [11:0] pct, input logic dbl);
		logic [12:0] r;
		r = dbl ? {pct, 1'b0} : {1'b0, pct};
		return r;
	endfunction

	function automatic logic overThr(input logic [15:0] meas, input logic [12:0] thr);
		logic r;
		r = meas > {3'h0, thr};
		return r;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	ocState_t         st_r;
	ocState_t         st_nxt;
	logic [2:0][15:0] sampAbs;
	logic [2:0][15:0] fund;
	logic [2:0][15:0] meas;
	logic [12:0]      thr;
	logic             armed;
	logic             winEnd;
	logic             acc;
	logic             wrDone;
	logic [3:0]       evSet;
	logic [3:0]       evClr;
	logic             addrOk;
	logic             badData;

	assign sampAbs[0] = absVal(phase1CurrentSample);
	assign sampAbs[1] = absVal(phase2CurrentSample);
	assign sampAbs[2] = absVal(phase3CurrentSample);
	assign fund[0]    = phase1FundamentalRms;
	assign fund[1]    = phase2FundamentalRms;
	assign fund[2]    = phase3FundamentalRms;

	always_comb begin
		st_nxt  = st_r;
		evSet   = 4'h0;
		evClr   = 4'h0;
		addrOk  = 1'b0;
		badData = 1'b0;

		// ----------------------------------------
		// Peak selection
		// ----------------------------------------
		// The peak restarts each window so a cleared fault lets the trip fall.
		winEnd = st_r.winCnt == 16'(PEAK_WINDOW - 1);
		if (sampleValid) begin
			st_nxt.winCnt = winEnd ? 16'h0000 : st_r.winCnt + 16'h0001;
			for (int i = 0; i < 3; i++) begin
				st_nxt.peak[i] = winEnd ? sampAbs[i] : maxVal(st_r.peak[i], sampAbs[i]);
			end
		end

		// ----------------------------------------
		// Instantaneous decision
		// ----------------------------------------
		thr = effThr(st_r.startPct, thresholdDoublingIn);
		armed = (st_r.mode != MODE_OFF) && !functionDisableIn;
		for (int i = 0; i < 3; i++) begin
			meas[i] = (st_r.mode == MODE_PEAK) ? st_nxt.peak[i] : fund[i];
			st_nxt.trip[i] = armed && overThr(meas[i], thr);
		end
		st_nxt.anyTrip = |st_nxt.trip;

		// ----------------------------------------
		// Events
		// ----------------------------------------
		evSet[2:0]            = st_nxt.trip & ~st_r.trip;
		evSet[`OC_EV_GEN_BIT] = st_nxt.anyTrip & ~st_r.anyTrip;

		// ----------------------------------------
		// APB slave
		// ----------------------------------------
		acc    = psel && penable;
		wrDone = acc && st_r.pready && pwrite && !st_r.pslverr;
		case (paddr)
			`OC_CTRL_OFS, `OC_START_OFS, `OC_STATUS_OFS, `OC_EVSTAT_OFS,
			`OC_EVEN_OFS, `OC_EVCLR_OFS, `OC_PEAK1_OFS, `OC_PEAK2_OFS,
			`OC_PEAK3_OFS: addrOk = 1'b1;
			default: addrOk = 1'b0;
		endcase
		if (pwrite && paddr == `OC_CTRL_OFS) begin
			badData = pwdata[`OC_MODE_MSB:0] == 2'h3;
		end
		if (pwrite && paddr == `OC_START_OFS) begin
			badData = (pwdata[31:12] != 20'h00000)
				|| (pwdata[`OC_START_MSB:0] < `OC_START_MIN)
				|| (pwdata[`OC_START_MSB:0] > `OC_START_MAX);
		end
		st_nxt.pready = acc && !st_r.pready;
		if (acc && !st_r.pready) begin
			st_nxt.pslverr = !addrOk || badData;
			st_nxt.prdata  = 32'h00000000;
			if (!pwrite) begin
				case (paddr)
					`OC_CTRL_OFS:   st_nxt.prdata = {30'h0, st_r.mode};
					`OC_START_OFS:  st_nxt.prdata = {20'h0, st_r.startPct};
					`OC_STATUS_OFS: st_nxt.prdata = {26'h0, thresholdDoublingIn,
						functionDisableIn, st_r.anyTrip, st_r.trip};
					`OC_EVSTAT_OFS: st_nxt.prdata = {28'h0, st_r.evStat};
					`OC_EVEN_OFS:   st_nxt.prdata = {28'h0, st_r.evEn};
					`OC_PEAK1_OFS:  st_nxt.prdata = {16'h0, st_r.peak[0]};
					`OC_PEAK2_OFS:  st_nxt.prdata = {16'h0, st_r.peak[1]};
					`OC_PEAK3_OFS:  st_nxt.prdata = {16'h0, st_r.peak[2]};
					default:        st_nxt.prdata = 32'h00000000;
				endcase
			end
		end else begin
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata  = 32'h00000000;
		end
		if (wrDone) begin
			case (paddr)
				`OC_CTRL_OFS:  st_nxt.mode     = opMode_t'(pwdata[`OC_MODE_MSB:0]);
				`OC_START_OFS: st_nxt.startPct = pwdata[`OC_START_MSB:0];
				`OC_EVEN_OFS:  st_nxt.evEn     = pwdata[3:0];
				`OC_EVCLR_OFS: evClr           = pwdata[3:0];
				default:       evClr           = 4'h0;
			endcase
		end

		// A clear landing with a new event keeps the event.
		st_nxt.evStat = (st_r.evStat & ~evClr) | evSet;
		st_nxt.irq    = |(st_nxt.evStat & st_nxt.evEn);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r          <= '0;
			st_r.mode     <= MODE_OFF;
			st_r.startPct <= `OC_START_DEF;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata          = st_r.prdata;
	assign pready          = st_r.pready;
	assign pslverr         = st_r.pslverr;
	assign phase1TripOut   = st_r.trip[0];
	assign phase2TripOut   = st_r.trip[1];
	assign phase3TripOut   = st_r.trip[2];
	assign anyPhaseTripOut = st_r.anyTrip;
	assign irq             = st_r.irq;

endmodule

/* bench/oc_front_end.sv */
`timescale 1ns/100ps
module oc_front_end (
	input  wire logic             clk,
	input  wire logic             fire,
	input  wire logic [2:0][15:0] sv,
	input  wire logic [2:0][15:0] fv,
	output logic                  sampleValid,
	output logic signed [15:0]    s1,
	output logic signed [15:0]    s2,
	output logic signed [15:0]    s3,
	output logic [15:0]           r1,
	output logic [15:0]           r2,
	output logic [15:0]           r3
);
	assign {r3, r2, r1} = fv;
	// Stale samples are inverted, so no one can lean on old data.
	always_ff @(posedge clk) begin
		sampleValid <= fire;
		{s3, s2, s1} <= fire ? sv : ~{s3, s2, s1};
	end
endmodule

/* bench/oc_sva.sv */
`timescale 1ns/100ps
module oc_sva (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        functionDisableIn,
	input wire logic        phase1TripOut,
	input wire logic        phase2TripOut,
	input wire logic        phase3TripOut,
	input wire logic        anyPhaseTripOut,
	input wire logic        irq
);
	wire [2:0] ph = {phase3TripOut, phase2TripOut, phase1TripOut};
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	any_or_a: assert property (anyPhaseTripOut == |ph)
		else $error("General trip mismatch.");
	dis_low_a: assert property ($past(functionDisableIn) |-> ph == 3'h0)
		else $error("Trip while disabled.");
	off_rst_a: assert property ($past(reset) |-> ph == 3'h0 && !irq)
		else $error("Output after reset.");
	rdy_wait_a: assert property ($rose(penable) && psel |=> pready)
		else $error("Ready late.");
	rdy_once_a: assert property (pready |=> !pready)
		else $error("Ready too long.");
	rdy_cause_a: assert property (pready |-> $past(psel && penable))
		else $error("Ready unasked.");
	rdat_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("Stray read data.");
	err_rdy_a: assert property (pslverr |-> pready)
		else $error("Error without ready.");
	cover property (anyPhaseTripOut);
	cover property (pready && pslverr);
	cover property ($rose(irq));
endmodule

bind three_phase_instant_overcurrent oc_sva i_oc_sva (.clk, .reset, .psel, .penable, .prdata,
	.pready, .pslverr, .functionDisableIn, .phase1TripOut, .phase2TripOut, .phase3TripOut,
	.anyPhaseTripOut, .irq);

/* bench/tb.sv */
`timescale 1ns/100ps
`include "instant_oc_map.svh"
module tb;
	typedef struct {logic [11:0] st; logic d; logic [47:0] f; logic [3:0] t;} row_t;
	logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, dis = 0, dbl = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, q, prdata;
	logic [47:0] sv = 0, fv = 0;
	logic pready, pslverr, sampleValid, t1, t2, t3, ta, irq, e;
	logic signed [15:0] s1, s2, s3;
	logic [15:0] r1, r2, r3;
	wire [3:0] trips = {ta, t3, t2, t1};
	int fail_count = 0, samples_checked = 0, cyc = 0;
	row_t rows [4] = '{'{12'h0c8, 0, 48'h0_00c8_00c9, 4'h9}, '{12'h0c8, 1, 48'h0_0191_0190, 4'ha},
		'{12'hbb8, 0, 48'hbb9_0000_0bb8, 4'hc}, '{12'h014, 0, 48'h15_0014_0015, 4'hd}};
	three_phase_instant_overcurrent #(.PEAK_WINDOW(4)) i_three_phase_instant_overcurrent (
		.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sampleValid, .phase1CurrentSample(s1), .phase2CurrentSample(s2),
		.phase3CurrentSample(s3), .phase1FundamentalRms(r1), .phase2FundamentalRms(r2),
		.phase3FundamentalRms(r3), .functionDisableIn(dis), .thresholdDoublingIn(dbl),
		.phase1TripOut(t1), .phase2TripOut(t2), .phase3TripOut(t3), .anyPhaseTripOut(ta), .irq);
	oc_front_end i_oc_front_end (.clk, .fire, .sv, .fv, .sampleValid, .s1, .s2, .s3, .r1, .r2, .r3);
	always #2 clk = ~clk;
	task test_done;
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			test_done();
		end
	end
	task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
		samples_checked++;
		if (s !== x) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	// The master waits for ready; only the run timeout ends a hang.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task hold(input logic [47:0] f);
		fv <= f;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset <= 0;
		apb(0, `OC_CTRL_OFS, 0);
		chk("mode", 0, q);
		apb(0, `OC_START_OFS, 0);
		chk("start", `OC_START_DEF, q);
		hold(48'hbb9);
		chk("off", 0, trips);
		apb(1, `OC_CTRL_OFS, 2);
		foreach (rows[i]) begin
			apb(1, `OC_START_OFS, rows[i].st);
			dbl <= rows[i].d;
			hold(rows[i].f);
			chk("trips", rows[i].t, trips);
		end
		dbl <= 0;
		dis <= 1;
		repeat (2) @(posedge clk);
		chk("blocked", 0, trips);
		dis <= 0;
		apb(1, `OC_START_OFS, 19);
		chk("range", 1, e);
		apb(1, 8'h40, 0);
		chk("unmapped", 1, e);
		apb(1, `OC_CTRL_OFS, 3);
		chk("mode3", 1, e);
		apb(0, `OC_CTRL_OFS, 0);
		chk("mode kept", 2, q);
		hold(0);
		apb(1, `OC_EVEN_OFS, 2);
		apb(1, `OC_EVCLR_OFS, 15);
		hold(48'h100);
		chk("masked", 0, irq);
		hold(48'h0100_0100);
		chk("irq", 1, irq);
		apb(1, `OC_EVCLR_OFS, 2);
		@(posedge clk);
		chk("cleared", 0, irq);
		apb(1, `OC_START_OFS, 200);
		apb(1, `OC_CTRL_OFS, 1);
		hold(0);
		sv <= 48'h0064_fe0c_0064;
		fire <= 1;
		@(posedge clk);
		fire <= 0;
		repeat (4) @(posedge clk);
		chk("peak", 4'ha, trips);
		test_done();
	end
endmodule
